/* File: program_sequencer_stack.sv */
/*
 Instruction sequencer: four-phase instruction cycle, overlapped fetch,
 10-bit program counter, accumulator data path, return stack and APB
 registers. Assumes program memory returns the word one cycle after the
 address and that interrupt requests arrive synchronous to clk_sys.
*/
// What this block does
// - Four non-overlapping phases from the system clock make one instruction cycle.
// - The first phase advances the counter and fetches; the fourth executes.
// - Fetch overlaps execution, so plain instructions take one cycle each.
// - Instructions that change the counter take two instruction cycles.
// - Arithmetic, logic, rotate and skip decisions use the 8-bit accumulator.
// - Sequential execution adds exactly one to the counter per instruction.
// - Jump, call, interrupt and reset load the counter directly.
// - A taken skip discards the fetched instruction and runs a dummy cycle.
// - The counter is two high bits plus a software-visible low byte.
// - The low byte reads and writes; a write jumps within the page.
// - A low byte write inserts one dummy cycle for the prefetch.
// - The stack holds only counter values and is invisible to software.
// - Call and interrupt acknowledge push the counter minus one onto the stack.
// - Both return instructions pop the newest saved counter value.
// - Reset sets the stack pointer to slot zero and empties the stack.
// - With the stack full, interrupts are recorded but acknowledged only later.
// - A call into a full stack still pushes and loses the oldest entry.
// - After reset fetching starts at address zero.
// - The counter addresses 1024 program words of 14 bits.
`timescale 1ns/1ns
module program_sequencer_stack import seq_pkg::*; (
	input wire logic clk_sys, // System clock, 20 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write.
	input wire logic [APB_AW-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	output logic [PC_W-1:0] memAddr, // Program memory word address.
	output logic memRead, // Program memory read strobe.
	input wire logic [INSTR_W-1:0] instrWord, // Program memory word.
	input wire logic intReq, // Enabled interrupt request.
	output logic intAck, // Interrupt acknowledge pulse.
	output logic [3:0] instructionPhaseClocks // One-hot phase strobes.
);
	// ****************************************
	// State
	// ****************************************
	logic [1:0] phaseCnt;
	logic [PC_W-1:0] pc_reg, pc_next, popData;
	logic [INSTR_W-1:0] fetchIr_reg, execIr_reg;
	logic fetchValid_reg, execValid_reg;
	logic [DATA_W-1:0] acc_reg, acc_next, pclVal_reg, imm;
	logic intEnable_reg, intFlag_reg, pclPend_reg;
	logic loadPc, flush, pclApply, ackNow, doPush, doPop;
	logic stackFull, isT4, execNow, apbAccess, apbWrite;
	logic [2:0] op, aluSel;

	phase_divider u_phase (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.phaseCnt_reg(phaseCnt),
		.phaseHot_reg(instructionPhaseClocks)
	);

	return_stack #(.DEPTH(STACK_DEPTH)) u_stack (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.push(doPush),
		.pop(doPop),
		.pushData(pc_reg - 10'h001),
		.popData(popData),
		.full(stackFull)
	);

	assign isT4 = (phaseCnt == PH_T4);
	assign execNow = isT4 && execValid_reg;
	assign op = execIr_reg[13:11];
	assign aluSel = execIr_reg[10:8];
	assign imm = execIr_reg[7:0];

	// ****************************************
	// Execute stage, decided in the fourth phase
	// ****************************************
	// The fetched word sits at pc_reg - 1 here, so that is the return address.
	always_comb begin
		acc_next = acc_reg;
		pc_next = pc_reg;
		loadPc = 1'b0;
		flush = 1'b0;
		pclApply = 1'b0;
		ackNow = 1'b0;
		doPush = 1'b0;
		doPop = 1'b0;
		if (execNow) begin
			case (op)
				OP_ALU: begin
					case (aluSel)
						ALU_ADD: acc_next = acc_reg + imm;
						ALU_AND: acc_next = acc_reg & imm;
						ALU_OR: acc_next = acc_reg | imm;
						ALU_XOR: acc_next = acc_reg ^ imm;
						ALU_ROTL: acc_next = {acc_reg[6:0], acc_reg[7]};
						ALU_INC: acc_next = acc_reg + 8'h01;
						ALU_DEC: acc_next = acc_reg - 8'h01;
						default: acc_next = imm;
					endcase
				end
				OP_JUMP: begin
					loadPc = 1'b1;
					pc_next = execIr_reg[PC_W-1:0];
					flush = 1'b1;
				end
				OP_CALL: begin
					loadPc = 1'b1;
					pc_next = execIr_reg[PC_W-1:0];
					flush = 1'b1;
					doPush = 1'b1;
				end
				OP_RETSUB, OP_RETINT: begin
					loadPc = 1'b1;
					pc_next = popData;
					flush = 1'b1;
					doPop = 1'b1;
				end
				OP_SKIPZ: begin
					flush = (acc_reg == 8'h00);
				end
				OP_DECSKIPZ: begin
					acc_next = acc_reg - 8'h01;
					flush = (acc_reg == 8'h01);
				end
				default: begin
					loadPc = 1'b1;
					pc_next = {pc_reg[PC_W-1:DATA_W], acc_reg};
					flush = 1'b1;
				end
			endcase
		end
		if (isT4 && !flush && pclPend_reg) begin
			pclApply = 1'b1;
			loadPc = 1'b1;
			pc_next = {pc_reg[PC_W-1:DATA_W], pclVal_reg};
			flush = 1'b1;
		end else if (isT4 && !flush && intFlag_reg && intEnable_reg && !stackFull) begin
			ackNow = 1'b1;
			loadPc = 1'b1;
			pc_next = INT_VECTOR;
			flush = 1'b1;
			doPush = 1'b1;
		end
	end

	// ****************************************
	// Program counter and fetch pipeline
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pc_reg <= RESET_VECTOR;
		end else if (phaseCnt == PH_T1) begin
			pc_reg <= pc_reg + 10'h001;
		end else if (loadPc) begin
			pc_reg <= pc_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			memAddr <= RESET_VECTOR;
			memRead <= 1'b0;
		end else begin
			memRead <= (phaseCnt == PH_T1);
			if (phaseCnt == PH_T1) begin
				memAddr <= pc_reg;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fetchIr_reg <= '0;
			fetchValid_reg <= 1'b0;
		end else if (phaseCnt == PH_T3) begin
			fetchIr_reg <= instrWord;
			fetchValid_reg <= 1'b1;
		end else if (flush) begin
			fetchValid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			execIr_reg <= '0;
			execValid_reg <= 1'b0;
		end else if (phaseCnt == PH_T1) begin
			execIr_reg <= fetchIr_reg;
			execValid_reg <= fetchValid_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			acc_reg <= ACC_RESET;
		end else begin
			acc_reg <= acc_next;
		end
	end

	// ****************************************
	// Interrupt request and acknowledge
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			intFlag_reg <= 1'b0;
			intAck <= 1'b0;
		end else begin
			intAck <= ackNow;
			if (intReq) begin
				intFlag_reg <= 1'b1;
			end else if (ackNow) begin
				intFlag_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// APB registers
	// ****************************************
	assign apbAccess = psel && penable && !pready;
	assign apbWrite = psel && penable && pready && pwrite;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= apbAccess;
			pslverr <= 1'b0;
			prdata <= '0;
			if (apbAccess) begin
				case (paddr)
					ADDR_PCL: prdata <= {24'h000000, pc_reg[DATA_W-1:0]};
					ADDR_CTRL: prdata <= {31'h00000000, intEnable_reg};
					ADDR_STATUS: begin
						prdata[STAT_PC_LSB +: PC_W] <= pc_reg;
						prdata[STAT_ACC_LSB +: DATA_W] <= acc_reg;
						prdata[STAT_INTFLAG_BIT] <= intFlag_reg;
						prdata[STAT_PCLPEND_BIT] <= pclPend_reg;
					end
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			intEnable_reg <= 1'b0;
		end else if (apbWrite && paddr == ADDR_CTRL) begin
			intEnable_reg <= pwdata[CTRL_INTEN_BIT];
		end
	end

	// A new write in the cycle the old one is applied keeps the new value pending.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pclPend_reg <= 1'b0;
			pclVal_reg <= 8'h00;
		end else if (apbWrite && paddr == ADDR_PCL) begin
			pclPend_reg <= 1'b1;
			pclVal_reg <= pwdata[DATA_W-1:0];
		end else if (pclApply) begin
			pclPend_reg <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_fetchAdvance;
		!sys_rst && phaseCnt == PH_T1 |=>
			memAddr == $past(pc_reg) && pc_reg == $past(pc_reg) + 10'h001;
	endproperty
	a_fetchAdvance: assert property (p_fetchAdvance) else $error("fetch step wrong");

	property p_onePerCycle;
		phaseCnt == PH_T1 && !loadPc ##1 !loadPc [*3] |=> pc_reg == $past(pc_reg, 4) + 10'h001;
	endproperty
	a_onePerCycle: assert property (p_onePerCycle) else $error("pc not +1");

	property p_jumpLoads;
		execNow && op == OP_JUMP |=> pc_reg == $past(execIr_reg[PC_W-1:0]);
	endproperty
	a_jumpLoads: assert property (p_jumpLoads) else $error("jump target lost");

	sequence s_dummyCycle;
		!fetchValid_reg ##1 !execValid_reg [*3];
	endsequence
	property p_flushDummy;
		isT4 && flush |=> s_dummyCycle;
	endproperty
	a_flushDummy: assert property (p_flushDummy) else $error("no dummy cycle");

	property p_pclPage;
		pclApply |=> pc_reg == {$past(pc_reg[PC_W-1:DATA_W]), $past(pclVal_reg)};
	endproperty
	a_pclPage: assert property (p_pclPage) else $error("pcl jump left page");

	property p_fullBlocksAck;
		stackFull |-> !ackNow;
	endproperty
	a_fullBlocksAck: assert property (p_fullBlocksAck) else $error("ack while full");

	property p_ackVectors;
		ackNow |=> intAck && pc_reg == INT_VECTOR && (!intFlag_reg || $past(intReq));
	endproperty
	a_ackVectors: assert property (p_ackVectors) else $error("ack not vectored");

	property p_addAcc;
		execNow && op == OP_ALU && aluSel == ALU_ADD |=> acc_reg == $past(acc_reg) + $past(imm);
	endproperty
	a_addAcc: assert property (p_addAcc) else $error("add result wrong");

	property p_resetStart;
		disable iff (1'b0) sys_rst |=> pc_reg == RESET_VECTOR && !stackFull && !execValid_reg;
	endproperty
	a_resetStart: assert property (p_resetStart) else $error("reset state wrong");
endmodule

/* File: seq_pkg.sv */
/*
 Shared constants of the program sequencer: register map, field positions,
 reset values, phase numbers and the instruction encoding.
 Assumes a single 20 MHz system clock and a 32-bit APB register bus.
*/
package seq_pkg;
	localparam int PC_W = 10;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int STACK_DEPTH = 4;
	localparam int APB_AW = 12;
	localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
	localparam logic [PC_W-1:0] INT_VECTOR = 10'h004;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	// ****************************************
	// Register offsets and fields
	// ****************************************
	localparam logic [APB_AW-1:0] ADDR_PCL = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h008;
	localparam int CTRL_INTEN_BIT = 0;
	localparam int STAT_PC_LSB = 0;
	localparam int STAT_ACC_LSB = 10;
	localparam int STAT_INTFLAG_BIT = 18;
	localparam int STAT_PCLPEND_BIT = 19;
	// ****************************************
	// Phases and instruction encoding
	// ****************************************
	localparam logic [1:0] PH_T1 = 2'h0;
	localparam logic [1:0] PH_T3 = 2'h2;
	localparam logic [1:0] PH_T4 = 2'h3;
	localparam logic [2:0] OP_ALU = 3'h0;
	localparam logic [2:0] OP_JUMP = 3'h1;
	localparam logic [2:0] OP_CALL = 3'h2;
	localparam logic [2:0] OP_RETSUB = 3'h3;
	localparam logic [2:0] OP_RETINT = 3'h4;
	localparam logic [2:0] OP_SKIPZ = 3'h5;
	localparam logic [2:0] OP_DECSKIPZ = 3'h6;
	localparam logic [2:0] OP_MOVPCL = 3'h7;
	localparam logic [2:0] ALU_ADD = 3'h0;
	localparam logic [2:0] ALU_AND = 3'h1;
	localparam logic [2:0] ALU_OR = 3'h2;
	localparam logic [2:0] ALU_XOR = 3'h3;
	localparam logic [2:0] ALU_ROTL = 3'h4;
	localparam logic [2:0] ALU_INC = 3'h5;
	localparam logic [2:0] ALU_DEC = 3'h6;
	localparam logic [2:0] ALU_LOAD = 3'h7;
endpackage

/* File: phase_divider.sv */
/*
 Free-running divider that splits the system clock into four instruction
 phases, given both as a count and as one-hot phase strobes.
 Assumes a synchronous, active-high reset.
*/
`timescale 1ns/1ns
module phase_divider import seq_pkg::*; (
	input wire logic clk_sys, // System clock.
	input wire logic sys_rst, // Synchronous reset.
	output logic [1:0] phaseCnt_reg, // Current phase number.
	output logic [3:0] phaseHot_reg // One-hot phase strobes.
);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			phaseCnt_reg <= PH_T1;
			phaseHot_reg <= 4'h1;
		end else begin
			phaseCnt_reg <= phaseCnt_reg + 2'h1;
			phaseHot_reg <= {phaseHot_reg[2:0], phaseHot_reg[3]};
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_phaseOneHot;
		$onehot(phaseHot_reg) && (phaseHot_reg[phaseCnt_reg] == 1'b1);
	endproperty
	a_phaseOneHot: assert property (p_phaseOneHot) else $error("phases overlap");

	sequence s_fullRound;
		phaseHot_reg == 4'h2 ##1 phaseHot_reg == 4'h4 ##1 phaseHot_reg == 4'h8
			##1 phaseHot_reg == 4'h1;
	endsequence
	property p_phaseOrder;
		!sys_rst && phaseHot_reg == 4'h1 |=> s_fullRound;
	endproperty
	a_phaseOrder: assert property (p_phaseOrder) else $error("phase order broken");
endmodule

/* File: return_stack.sv */
/*
 Return-address stack of program counter values with no software access.
 A push into a full stack overwrites the oldest entry. Assumes push and
 pop never come together and DEPTH is a power of two.
*/
`timescale 1ns/1ns
module return_stack import seq_pkg::*; #(
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic clk_sys, // System clock.
	input wire logic sys_rst, // Synchronous reset.
	input wire logic push, // Save pushData.
	input wire logic pop, // Drop the newest entry.
	input wire logic [PC_W-1:0] pushData, // Address to save.
	output logic [PC_W-1:0] popData, // Newest saved address.
	output logic full // Every level holds an address.
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	logic [PC_W-1:0] slots [DEPTH];
	logic [PW-1:0] ptr_reg;
	logic [CW-1:0] count_reg;

	assign full = (count_reg == DEPTH_C);
	assign popData = slots[ptr_reg - PW'(1)];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			slots[ptr_reg] <= pushData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ptr_reg <= '0;
			count_reg <= '0;
		end else if (push) begin
			ptr_reg <= ptr_reg + PW'(1);
			count_reg <= full ? count_reg : count_reg + CW'(1);
		end else if (pop && count_reg != '0) begin
			ptr_reg <= ptr_reg - PW'(1);
			count_reg <= count_reg - CW'(1);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_overflowStaysFull;
		full && push |=> full && popData == $past(pushData);
	endproperty
	a_overflowStaysFull: assert property (p_overflowStaysFull) else $error("overflow lost");

	property p_pushThenPop;
		push && !full ##1 (!push && !pop) [*7] ##1 pop |=> count_reg == $past(count_reg, 9);
	endproperty
	a_pushThenPop: assert property (p_pushThenPop) else $error("pop count wrong");
endmodule

/* File: prog_mem_model.sv */
/*
 Program memory model: 1024 words of 14 bits, loaded by the bench.
 Assumes the sequencer samples the word in the cycle after its fetch strobe.
*/
`timescale 1ns/1ns
module prog_mem_model import seq_pkg::*; (
	input wire logic clk_sys, // System clock.
	input wire logic [PC_W-1:0] memAddr, // Word address.
	input wire logic memRead, // Fetch strobe.
	output logic [INSTR_W-1:0] instrWord // Fetched word.
);
	logic [INSTR_W-1:0] words [0:1023];
	logic [INSTR_W-1:0] word_reg = 14'h0000;
	logic [INSTR_W-1:0] junk_reg = 14'h2AAA;
	logic valid_reg = 1'b0;
	// Outside the answer cycle the word toggles so a late sample cannot pass.
	always @(posedge clk_sys) begin
		valid_reg <= memRead;
		junk_reg <= ~junk_reg;
		if (memRead) begin
			word_reg <= words[memAddr];
		end
	end
	assign instrWord = valid_reg ? word_reg : junk_reg;
endmodule

/* File: tb_top.sv */
/*
 Self-checking bench of the program sequencer: fetch order, branches,
 skips, stack, interrupts and APB registers. Assumes prog_mem_model.
*/
`timescale 1ns/1ns
module tb_top import seq_pkg::*; ;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [PC_W-1:0] memAddr;
	logic memRead;
	logic [INSTR_W-1:0] instrWord;
	logic intReq = 1'b0;
	logic intAck;
	logic [3:0] instructionPhaseClocks;
	int err_count = 0;
	int n_compared = 0;
	int cycleCount = 0;
	int ackCount = 0;
	logic [PC_W-1:0] ackAddr = 10'h000;
	logic [PC_W-1:0] fq[$];
	logic [PC_W-1:0] expq[$];
	always #25 clk_sys = ~clk_sys;
	program_sequencer_stack program_sequencer_stack_inst (.clk_sys, .sys_rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .memAddr,
		.memRead, .instrWord, .intReq, .intAck, .instructionPhaseClocks);
	prog_mem_model prog_mem_model_inst (.clk_sys, .memAddr, .memRead, .instrWord);
	// ****************************************
	// Monitor, timeout and helpers
	// ****************************************
	always @(posedge clk_sys) begin
		cycleCount++;
		if (!sys_rst && memRead === 1'b1) begin
			fq.push_back(memAddr);
		end
		if (intAck === 1'b1) begin
			ackCount++;
			ackAddr = memAddr;
		end
		if (cycleCount == 5000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
		n_compared++;
		if (got !== expv) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, expv, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		chk("apb ready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		fq.delete();
		ackCount = 0;
	endtask
	task automatic put(input int a, input logic [2:0] op, input logic [10:0] f);
		prog_mem_model_inst.words[a] = {op, f};
	endtask
	task automatic blank_mem();
		for (int i = 0; i < 1024; i++) begin
			put(i, OP_JUMP, 11'h3FF);
		end
		expq.delete();
	endtask
	task automatic exp_run(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			expq.push_back(PC_W'(i));
		end
	endtask
	task automatic check_fetch();
		foreach (expq[i]) begin
			chk("fetch address", 32'(expq[i]), (i < fq.size()) ? 32'(fq[i]) : 32'hFFFF);
		end
	endtask
	function automatic logic [7:0] alu_exp(input logic [2:0] op, input logic [7:0] a,
			input logic [7:0] b);
		case (op)
			ALU_ADD: return a + b;
			ALU_AND: return a & b;
			ALU_OR: return a | b;
			ALU_XOR: return a ^ b;
			ALU_ROTL: return {a[6:0], a[7]};
			ALU_INC: return a + 8'h01;
			ALU_DEC: return a - 8'h01;
			default: return b;
		endcase
	endfunction
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] r;
		logic [7:0] q;
		logic [7:0] acc;
		logic [7:0] imm;
		logic [31:0] rd;
		logic err;
		int k;
		void'($urandom(32'h6679));
		r = 8'h30 + 8'($urandom_range(0, 175));
		blank_mem();
		put(0, OP_ALU, {ALU_LOAD, 8'($urandom)});
		put(1, OP_CALL, 11'h010);
		put(2, OP_JUMP, 11'h020);
		put(16, OP_RETSUB, 11'h000);
		put(32, OP_ALU, {ALU_LOAD, 8'h00});
		put(33, OP_SKIPZ, 11'h000);
		put(35, OP_ALU, {ALU_LOAD, 8'h01});
		put(36, OP_DECSKIPZ, 11'h000);
		put(38, OP_ALU, {ALU_LOAD, r});
		put(39, OP_MOVPCL, 11'h000);
		acc = r;
		for (int i = 0; i < 8; i++) begin
			imm = 8'($urandom);
			put(r + i, OP_ALU, {3'(i), imm});
			acc = alu_exp(3'(i), acc, imm);
		end
		put(r + 8, OP_JUMP, {3'h0, r + 8'h08});
		exp_run(0, 2);
		exp_run(16, 17);
		exp_run(2, 3);
		exp_run(32, 40);
		exp_run(r, r + 9);
		exp_run(r + 8, r + 9);
		do_reset();
		for (int i = 0; i < 5; i++) begin
			@(negedge clk_sys);
			chk("phase strobes", 32'(1 << (i % 4)), 32'(instructionPhaseClocks));
		end
		repeat (150) @(posedge clk_sys);
		check_fetch();
		apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF, rd, err);
		chk("status write error", 32'h0, {31'h0, err});
		apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
		chk("accumulator", 32'(acc), 32'(rd[STAT_ACC_LSB +: 8]));
		apb(1'b0, 12'h00C, 32'h0, rd, err);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		q = 8'hF0 + 8'($urandom_range(0, 7));
		put(q, OP_JUMP, {3'h0, q});
		apb(1'b1, ADDR_PCL, {24'h0, q}, rd, err);
		k = 0;
		while (memAddr !== {2'b00, q} && k < 80) begin
			@(posedge clk_sys);
			k++;
		end
		chk("page jump target", {22'h0, 2'b00, q}, 32'(memAddr));
		apb(1'b0, ADDR_PCL, 32'h0, rd, err);
		chk("low byte read", 32'h1, 32'(rd[31:8] == 24'h0 && rd[7:0] - q <= 2));
		blank_mem();
		put(0, OP_CALL, 11'h100);
		for (int i = 0; i < 4; i++) begin
			put(256 + 16 * i, OP_CALL, 11'(272 + 16 * i));
		end
		put(320, OP_RETSUB, 11'h000);
		for (int i = 0; i < 3; i++) begin
			put(273 + 16 * i, OP_RETSUB, 11'h000);
		end
		put(257, OP_JUMP, 11'h101);
		put(4, OP_RETINT, 11'h000);
		exp_run(0, 1);
		for (int i = 0; i < 5; i++) begin
			exp_run(256 + 16 * i, 257 + 16 * i);
		end
		exp_run(305, 305);
		exp_run(4, 5);
		exp_run(305, 306);
		exp_run(289, 290);
		exp_run(273, 274);
		exp_run(257, 258);
		exp_run(257, 258);
		do_reset();
		apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		chk("interrupt enable", 32'h1, rd);
		k = 0;
		while (memAddr !== 10'h130 && k < 200) begin
			@(posedge clk_sys);
			k++;
		end
		intReq <= 1'b1;
		@(posedge clk_sys);
		intReq <= 1'b0;
		repeat (200) @(posedge clk_sys);
		check_fetch();
		chk("ack count", 32'h1, 32'(ackCount));
		chk("ack address", 32'h131, 32'(ackAddr));
		complete_run();
	end
endmodule
